// ==== rtl/hrx_modulator.sv ====
// module: fine-resolution modulator extension with digital compare, over classic Wishbone
//
// Contract
// - one fine edge delay line per modulator instance
// - delay lines calibrated via a dedicated separate calibration line
// - fine placement on output A only; output B stays clock-granular
// - fine edges come from compare-A extension plus phase extension, or plus period extension in period mode
// - fine placement for single-edge duty/phase and dual-edge period control
// - period mode with dual edge makes output B unavailable
// - mirror writes for period and compare A go to the shadow stage
// - power and step registers exist only in the first instance
// - filter offset has one shadow; its counters have none
// - counter capture register has one shadow holding the count
// - digital compare events come from comparator and trip input levels
// - period control repeats per instance at 0x40 stride
// - protected registers ignore writes unless protected write is enabled
`timescale 1ns/1ps
module hrx_modulator
  import hrx_pkg::*;
#(
  parameter int NUM_MOD = 4,
  parameter int FINE_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [17:0] adr_i,
  input wire logic [1:0] sel_i,
  input wire logic [15:0] dat_i,
  output logic [15:0] dat_o,
  output logic ack_o,
  output logic err_o,
  input wire logic protected_write_enable_i,
  input wire logic [NUM_MOD-1:0] shadow_load_i,
  input wire logic [NUM_MOD-1:0][15:0] time_base_count_i,
  input wire logic [NUM_MOD-1:0] comparator_output_i,
  input wire logic [NUM_MOD-1:0] trip_zone_input_i,
  input wire logic [NUM_MOD-1:0] coarse_a_i,
  input wire logic [NUM_MOD-1:0] coarse_b_i,
  output logic [NUM_MOD-1:0] modulator_output_a_o,
  output logic [NUM_MOD-1:0] modulator_output_b_o,
  output logic [NUM_MOD-1:0][FINE_W-1:0] micro_edge_positioner_o,
  output logic [NUM_MOD-1:0] dc_event_a_o,
  output logic [NUM_MOD-1:0] dc_event_b_o,
  output logic cal_busy_o
);
  // ******************************************
  // bus decode
  // ******************************************
  logic [15:0] word_idx;
  logic [15:0] rel_idx;
  logic [1:0] inst;
  logic [15:0] inst_full;
  logic acc;
  logic wr;
  logic hit;
  logic prot;
  logic wr_ok;
  logic [15:0] rdata;
  logic ack_reg;

  assign word_idx = adr_i[17:2];
  assign inst_full = (word_idx - IDX_FINE_RES_POWER_CTRL + ONE_COUNT) / INSTANCE_STRIDE;
  assign inst = inst_full[1:0];
  assign rel_idx = (word_idx & INSTANCE_MASK) | (IDX_FINE_PERIOD_CONTROL & ~INSTANCE_MASK);
  assign acc = cyc_i && stb_i && !ack_reg;
  assign wr = acc && we_i && (sel_i != 2'b00) && hit;
  assign wr_ok = wr && (!prot || protected_write_enable_i);

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic [1:0] sel);
    merge = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
  endfunction

  // ******************************************
  // registers
  // ******************************************
  logic [15:0] pwr_reg;
  logic [15:0] step_reg;
  logic [NUM_MOD-1:0][15:0] pctl_reg, tripsel_reg, dca_reg, dcb_reg, fctl_reg, capct_reg;
  logic [NUM_MOD-1:0][15:0] foff_sh_reg, foff_act_reg, fwin_reg, foffcnt_reg, fwincnt_reg;
  logic [NUM_MOD-1:0][15:0] cap_sh_reg, cap_act_reg, phs_fine_reg;
  logic [NUM_MOD-1:0] blank_reg;
  hrx_timing_t shadow_reg [NUM_MOD];
  hrx_timing_t active_reg [NUM_MOD];
  hrx_cal_state_t cal_state;
  logic [7:0] cal_count;

  logic [NUM_MOD-1:0] sel_inst;
  always_comb begin
    for (int i = 0; i < NUM_MOD; i++) begin
      sel_inst[i] = (inst == 2'(i));
    end
  end

  always_comb begin
    hit = 1'b1;
    prot = 1'b0;
    rdata = RESET_VALUE;
    if (int'(inst_full) >= NUM_MOD) begin
      hit = 1'b0;
    end else if (word_idx == IDX_FINE_RES_POWER_CTRL) begin
      rdata = pwr_reg;
    end else if (word_idx == IDX_EDGE_POSITIONER_STEP) begin
      rdata = step_reg;
    end else if (rel_idx == IDX_FINE_PERIOD_CONTROL) begin
      rdata = pctl_reg[inst];
      prot = 1'b1;
    end else if (rel_idx == IDX_PERIOD_EXTENSION_MIRROR) begin
      rdata = {8'h00, shadow_reg[inst].period_fine};
    end else if (rel_idx == IDX_PERIOD_MIRROR) begin
      rdata = shadow_reg[inst].period;
    end else if (rel_idx == IDX_COMPARE_A_EXTENSION_MIRROR) begin
      rdata = {8'h00, shadow_reg[inst].cmpa_fine};
    end else if (rel_idx == IDX_COMPARE_A_MIRROR) begin
      rdata = shadow_reg[inst].cmpa;
    end else if (rel_idx == IDX_COMPARE_TRIP_SELECT) begin
      rdata = tripsel_reg[inst];
      prot = 1'b1;
    end else if (rel_idx == IDX_COMPARE_A_CONTROL) begin
      rdata = dca_reg[inst];
      prot = 1'b1;
    end else if (rel_idx == IDX_COMPARE_B_CONTROL) begin
      rdata = dcb_reg[inst];
      prot = 1'b1;
    end else if (rel_idx == IDX_COMPARE_FILTER_CONTROL) begin
      rdata = fctl_reg[inst];
      prot = 1'b1;
    end else if (rel_idx == IDX_COMPARE_CAPTURE_CONTROL) begin
      rdata = capct_reg[inst];
      prot = 1'b1;
    end else if (rel_idx == IDX_FILTER_OFFSET_VALUE) begin
      rdata = foff_sh_reg[inst];
    end else if (rel_idx == IDX_FILTER_OFFSET_COUNTER) begin
      rdata = foffcnt_reg[inst];
    end else if (rel_idx == IDX_FILTER_WINDOW_VALUE) begin
      rdata = fwin_reg[inst];
    end else if (rel_idx == IDX_FILTER_WINDOW_COUNTER) begin
      rdata = fwincnt_reg[inst];
    end else if (rel_idx == IDX_COMPARE_COUNT_CAPTURE) begin
      rdata = cap_act_reg[inst];
    end else if (rel_idx == IDX_PHASE_EXTENSION) begin
      rdata = phs_fine_reg[inst];
    end else if (rel_idx == IDX_ACTIVE_PERIOD) begin
      rdata = active_reg[inst].period;
    end else if (rel_idx == IDX_ACTIVE_COMPARE_A) begin
      rdata = active_reg[inst].cmpa;
    end else if (rel_idx == IDX_MOD_STATUS) begin
      rdata = {13'h0000, blank_reg[inst], dc_event_b_o[inst], dc_event_a_o[inst]};
    end else begin
      hit = 1'b0;
    end
  end

  // ******************************************
  // bus answer
  // ******************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_o <= RESET_VALUE;
      err_o <= 1'b0;
    end else begin
      ack_reg <= acc && hit;
      err_o <= acc && !hit && !err_o;
      dat_o <= (acc && hit) ? rdata : RESET_VALUE;
    end
  end
  assign ack_o = ack_reg;

  // ******************************************
  // first-instance power and step
  // ******************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_reg <= RESET_VALUE;
      step_reg <= RESET_VALUE;
    end else if (wr_ok && word_idx == IDX_FINE_RES_POWER_CTRL) begin
      pwr_reg <= merge(pwr_reg, dat_i, sel_i);
    end else if (wr_ok && word_idx == IDX_EDGE_POSITIONER_STEP) begin
      step_reg <= merge(step_reg, dat_i, sel_i);
    end else if (cal_state == CAL_DONE) begin
      step_reg <= {8'h00, cal_count};
    end
  end

  // ******************************************
  // calibration line
  // ******************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal_state <= CAL_IDLE;
      cal_count <= 8'h00;
    end else begin
      case (cal_state)
        CAL_IDLE: begin
          if (pwr_reg[PWR_CAL_EN_BIT]) begin
            cal_state <= CAL_RUN;
            cal_count <= 8'h00;
          end
        end
        CAL_RUN: begin
          cal_count <= cal_count + FINE_ONE;
          if (&cal_count[6:0]) begin
            cal_state <= CAL_DONE;
          end
        end
        default: begin
          cal_state <= CAL_IDLE;
        end
      endcase
    end
  end
  assign cal_busy_o = (cal_state != CAL_IDLE);

  // ******************************************
  // per-instance logic
  // ******************************************
  for (genvar g = 0; g < NUM_MOD; g++) begin : g_mod
    logic w;
    logic trip_a;
    logic trip_b;
    assign w = wr_ok && sel_inst[g];
    // shadow and active timing
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        shadow_reg[g] <= '0;
        active_reg[g] <= '0;
      end else begin
        if (w && rel_idx == IDX_PERIOD_MIRROR) begin
          shadow_reg[g].period <= merge(shadow_reg[g].period, dat_i, sel_i);
        end
        if (w && rel_idx == IDX_PERIOD_EXTENSION_MIRROR) begin
          shadow_reg[g].period_fine <= dat_i[7:0];
        end
        if (w && rel_idx == IDX_COMPARE_A_MIRROR) begin
          shadow_reg[g].cmpa <= merge(shadow_reg[g].cmpa, dat_i, sel_i);
        end
        if (w && rel_idx == IDX_COMPARE_A_EXTENSION_MIRROR) begin
          shadow_reg[g].cmpa_fine <= dat_i[7:0];
        end
        if (shadow_load_i[g]) begin
          active_reg[g] <= shadow_reg[g];
        end
      end
    end
    // control registers
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pctl_reg[g] <= RESET_VALUE;
        tripsel_reg[g] <= RESET_VALUE;
        dca_reg[g] <= RESET_VALUE;
        dcb_reg[g] <= RESET_VALUE;
        fctl_reg[g] <= RESET_VALUE;
        capct_reg[g] <= RESET_VALUE;
        foff_sh_reg[g] <= RESET_VALUE;
        fwin_reg[g] <= RESET_VALUE;
        phs_fine_reg[g] <= RESET_VALUE;
      end else if (w) begin
        if (rel_idx == IDX_FINE_PERIOD_CONTROL) pctl_reg[g] <= merge(pctl_reg[g], dat_i, sel_i);
        if (rel_idx == IDX_COMPARE_TRIP_SELECT) tripsel_reg[g] <= dat_i;
        if (rel_idx == IDX_COMPARE_A_CONTROL) dca_reg[g] <= dat_i;
        if (rel_idx == IDX_COMPARE_B_CONTROL) dcb_reg[g] <= dat_i;
        if (rel_idx == IDX_COMPARE_FILTER_CONTROL) fctl_reg[g] <= dat_i;
        if (rel_idx == IDX_COMPARE_CAPTURE_CONTROL) capct_reg[g] <= dat_i;
        if (rel_idx == IDX_FILTER_OFFSET_VALUE) foff_sh_reg[g] <= dat_i;
        if (rel_idx == IDX_FILTER_WINDOW_VALUE) fwin_reg[g] <= dat_i;
        if (rel_idx == IDX_PHASE_EXTENSION) phs_fine_reg[g] <= dat_i;
      end
    end
    // digital compare events from levels
    assign trip_a = tripsel_reg[g][TRIPSEL_A_BIT] ? trip_zone_input_i[g] : comparator_output_i[g];
    assign trip_b = tripsel_reg[g][TRIPSEL_B_BIT] ? trip_zone_input_i[g] : comparator_output_i[g];
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        dc_event_a_o[g] <= 1'b0;
        dc_event_b_o[g] <= 1'b0;
      end else begin
        dc_event_a_o[g] <= dca_reg[g][DCCTL_EN_BIT] && !blank_reg[g] &&
                           (trip_a == dca_reg[g][DCCTL_HIGH_BIT]);
        dc_event_b_o[g] <= dcb_reg[g][DCCTL_EN_BIT] && !blank_reg[g] &&
                           (trip_b == dcb_reg[g][DCCTL_HIGH_BIT]);
      end
    end
    // blanking filter: offset then window, live counters
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        foff_act_reg[g] <= RESET_VALUE;
        foffcnt_reg[g] <= RESET_VALUE;
        fwincnt_reg[g] <= RESET_VALUE;
        blank_reg[g] <= 1'b0;
      end else if (shadow_load_i[g]) begin
        foff_act_reg[g] <= foff_sh_reg[g];
        foffcnt_reg[g] <= foff_sh_reg[g];
        fwincnt_reg[g] <= RESET_VALUE;
        blank_reg[g] <= 1'b0;
      end else if (fctl_reg[g][FCTL_EN_BIT]) begin
        if (foffcnt_reg[g] != RESET_VALUE) begin
          foffcnt_reg[g] <= foffcnt_reg[g] - ONE_COUNT;
          if (foffcnt_reg[g] == ONE_COUNT) begin
            fwincnt_reg[g] <= fwin_reg[g];
            blank_reg[g] <= (fwin_reg[g] != RESET_VALUE);
          end
        end else if (fwincnt_reg[g] != RESET_VALUE) begin
          fwincnt_reg[g] <= fwincnt_reg[g] - ONE_COUNT;
          blank_reg[g] <= (fwincnt_reg[g] != ONE_COUNT);
        end
      end
    end
    // counter capture with one shadow stage
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cap_sh_reg[g] <= RESET_VALUE;
        cap_act_reg[g] <= RESET_VALUE;
      end else if (capct_reg[g][CAPCT_EN_BIT] && dc_event_a_o[g]) begin
        cap_sh_reg[g] <= time_base_count_i[g];
        if (!capct_reg[g][CAPCT_SHDW_BIT]) cap_act_reg[g] <= time_base_count_i[g];
      end else if (shadow_load_i[g] && capct_reg[g][CAPCT_SHDW_BIT]) begin
        cap_act_reg[g] <= cap_sh_reg[g];
      end
    end
    // output paths: fine edge on A only, B gated in period mode
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        modulator_output_a_o[g] <= 1'b0;
        modulator_output_b_o[g] <= 1'b0;
        micro_edge_positioner_o[g] <= '0;
      end else begin
        modulator_output_a_o[g] <= coarse_a_i[g];
        modulator_output_b_o[g] <= coarse_b_i[g] && !pctl_reg[g][PCTL_PERIOD_EN_BIT];
        micro_edge_positioner_o[g] <= pctl_reg[g][PCTL_PERIOD_EN_BIT] ?
          FINE_W'(active_reg[g].period_fine + active_reg[g].cmpa_fine) :
          FINE_W'(active_reg[g].cmpa_fine + phs_fine_reg[g][7:0]);
      end
    end
  end

  // ******************************************
  // assertions
  // ******************************************
  property p_b_off;
    @(posedge clk_i) disable iff (rst_i)
      (pctl_reg[0][PCTL_PERIOD_EN_BIT] && $past(pctl_reg[0][PCTL_PERIOD_EN_BIT]))
      |-> !modulator_output_b_o[0];
  endproperty
  a_b_off: assert property (p_b_off) else $error("b output active in period mode");
  property p_prot;
    @(posedge clk_i) disable iff (rst_i)
      (wr && prot && !protected_write_enable_i) |=> $stable(pctl_reg) && $stable(tripsel_reg);
  endproperty
  a_prot: assert property (p_prot) else $error("protected write taken");
  property p_ack;
    @(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack held two cycles");
  property p_err;
    @(posedge clk_i) disable iff (rst_i) err_o |=> !err_o;
  endproperty
  a_err: assert property (p_err) else $error("err held two cycles");
  property p_a_path;
    @(posedge clk_i) disable iff (rst_i)
      !$past(rst_i) |-> modulator_output_a_o == $past(coarse_a_i);
  endproperty
  a_a_path: assert property (p_a_path) else $error("a output not following coarse a");
  property p_dc_off;
    @(posedge clk_i) disable iff (rst_i)
      !$past(dca_reg[0][DCCTL_EN_BIT]) |-> !dc_event_a_o[0];
  endproperty
  a_dc_off: assert property (p_dc_off) else $error("compare event while disabled");
endmodule // hrx_modulator

// ==== rtl/hrx_pkg.sv ====
// package: register map, field layouts and constants of the fine-resolution extension block
package hrx_pkg;
  // ******************************************
  // register indices (byte address = 4 * index)
  // ******************************************
  localparam logic [15:0] IDX_FINE_RES_POWER_CTRL = 16'h6821;
  localparam logic [15:0] IDX_EDGE_POSITIONER_STEP = 16'h6826;
  localparam logic [15:0] IDX_FINE_PERIOD_CONTROL = 16'h6828;
  localparam logic [15:0] IDX_PERIOD_EXTENSION_MIRROR = 16'h682a;
  localparam logic [15:0] IDX_PERIOD_MIRROR = 16'h682b;
  localparam logic [15:0] IDX_COMPARE_A_EXTENSION_MIRROR = 16'h682c;
  localparam logic [15:0] IDX_COMPARE_A_MIRROR = 16'h682d;
  localparam logic [15:0] IDX_COMPARE_TRIP_SELECT = 16'h6830;
  localparam logic [15:0] IDX_COMPARE_A_CONTROL = 16'h6831;
  localparam logic [15:0] IDX_COMPARE_B_CONTROL = 16'h6832;
  localparam logic [15:0] IDX_COMPARE_FILTER_CONTROL = 16'h6833;
  localparam logic [15:0] IDX_COMPARE_CAPTURE_CONTROL = 16'h6834;
  localparam logic [15:0] IDX_FILTER_OFFSET_VALUE = 16'h6835;
  localparam logic [15:0] IDX_FILTER_OFFSET_COUNTER = 16'h6836;
  localparam logic [15:0] IDX_FILTER_WINDOW_VALUE = 16'h6837;
  localparam logic [15:0] IDX_FILTER_WINDOW_COUNTER = 16'h6838;
  localparam logic [15:0] IDX_COMPARE_COUNT_CAPTURE = 16'h6839;
  // own registers: phase extension, active values and status
  localparam logic [15:0] IDX_PHASE_EXTENSION = 16'h6822;
  localparam logic [15:0] IDX_ACTIVE_PERIOD = 16'h6823;
  localparam logic [15:0] IDX_ACTIVE_COMPARE_A = 16'h6824;
  localparam logic [15:0] IDX_MOD_STATUS = 16'h6825;
  localparam logic [15:0] INSTANCE_STRIDE = 16'h0040;
  localparam logic [15:0] INSTANCE_MASK = 16'h003f;
  localparam logic [15:0] RESET_VALUE = 16'h0000;
  localparam logic [15:0] ONE_COUNT = 16'h0001;
  localparam logic [7:0] FINE_ONE = 8'h01;

  // ******************************************
  // field positions
  // ******************************************
  localparam int PCTL_PERIOD_EN_BIT = 0;   // dual-edge period mode
  localparam int PWR_CAL_EN_BIT = 0;       // calibration line on
  localparam int TRIPSEL_A_BIT = 0;        // 0 comparator, 1 trip input
  localparam int TRIPSEL_B_BIT = 1;
  localparam int DCCTL_EN_BIT = 0;         // digital compare event enable
  localparam int DCCTL_HIGH_BIT = 1;       // event on high level
  localparam int FCTL_EN_BIT = 0;          // blanking window enable
  localparam int CAPCT_EN_BIT = 0;         // capture enable
  localparam int CAPCT_SHDW_BIT = 1;       // 1 capture through shadow
  localparam int CAL_STEP_LSB = 0;
  localparam int CAL_STEP_W = 8;

  // ******************************************
  // carrier types
  // ******************************************
  typedef struct packed {
    logic [15:0] period;
    logic [7:0] period_fine;
    logic [15:0] cmpa;
    logic [7:0] cmpa_fine;
  } hrx_timing_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [17:0] adr;
    logic [15:0] dat;
  } hrx_wb_req_t;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_RUN = 2'b01,
    CAL_DONE = 2'b11
  } hrx_cal_state_t;
endpackage

// ==== testbench/test_hrx_modulator.sv ====
// testbench: self-checking bench of the fine-resolution extension block
`timescale 1ns/1ps
module test_hrx_modulator;
  import hrx_pkg::*;
  localparam int NM = 4;
  localparam int TMO = 20000;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o, pwe, cal_busy_o, busy_seen;
  logic [17:0] adr_i;
  logic [1:0] sel_i;
  logic [15:0] dat_i, dat_o, rd, rnd, o;
  logic [NM-1:0] ld, cmp, trip, ca, cb, oa, ob, ea, eb;
  logic [NM-1:0][15:0] tbc;
  logic [NM-1:0][7:0] micro_edge_positioner;
  logic [15:0] mdl [int];
  logic [15:0] sh [int];
  int err_count, n_checks, cyc_cnt;

  // ******************************************
  // design and clock
  // ******************************************
  hrx_modulator #(.NUM_MOD(NM), .FINE_W(8)) i_hrx_modulator (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .err_o(err_o), .protected_write_enable_i(pwe), .shadow_load_i(ld),
    .time_base_count_i(tbc), .comparator_output_i(cmp), .trip_zone_input_i(trip),
    .coarse_a_i(ca), .coarse_b_i(cb), .modulator_output_a_o(oa),
    .modulator_output_b_o(ob), .micro_edge_positioner_o(micro_edge_positioner), .dc_event_a_o(ea),
    .dc_event_b_o(eb), .cal_busy_o(cal_busy_o));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // ******************************************
  // helpers
  // ******************************************
  function automatic logic [15:0] nx();
    rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
    return rnd;
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt >= TMO) begin
      err_count++;
      close_out();
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic bus(input logic w, input logic [15:0] idx, input logic [15:0] d,
                     output logic e);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= 2'b11;
    dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1 && err_o !== 1'b1);
    rd = dat_o;
    e = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // write with model update; period and compare A mirrors land in the shadow only
  task automatic wr(input logic [15:0] idx, input logic [15:0] d, input logic xerr);
    logic e;
    logic [5:0] off;
    off = idx[5:0];
    bus(1'b1, idx, d, e);
    chk("bus_err", {15'h0, xerr}, {15'h0, e});
    if (!xerr) begin
      if (off == 6'h2b || off == 6'h2d) begin
        sh[idx] = d;
      end else if (off == 6'h36 || off == 6'h38 || off == 6'h39 ||
                   (off >= 6'h23 && off <= 6'h25)) begin
        off = off;
      end else if (off == 6'h28 || (off >= 6'h30 && off <= 6'h34)) begin
        if (pwe) mdl[idx] = d;
      end else begin
        mdl[idx] = d;
      end
    end
  endtask

  task automatic rdc(input string name, input logic [15:0] idx);
    logic e;
    bus(1'b0, idx, 16'h0000, e);
    chk(name, mdl.exists(idx) ? mdl[idx] : RESET_VALUE, rd);
  endtask

  // shadow to active for instance n: period and compare A
  task automatic load(input int n);
    o = INSTANCE_STRIDE * n;
    ld <= 4'(1 << n);
    @(posedge clk_i);
    ld <= '0;
    @(posedge clk_i);
    if (sh.exists(16'h682b + o)) mdl[16'h6823 + o] = sh[16'h682b + o];
    if (sh.exists(16'h682d + o)) mdl[16'h6824 + o] = sh[16'h682d + o];
  endtask

  // ******************************************
  // main sequence
  // ******************************************
  initial begin
    {rst_i, cyc_i, stb_i, we_i, pwe} = 5'b10000;
    adr_i = '0;
    sel_i = '0;
    dat_i = '0;
    {ld, cmp, trip, ca, cb} = '0;
    tbc = '0;
    rnd = 16'ha56e;
    err_count = 0;
    n_checks = 0;
    cyc_cnt = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("reset_b", 16'h0000, {12'h0, ob});
    chk("reset_dc", 16'h0000, {8'h0, ea, eb});
    $display("test reset done");
    wr(IDX_FINE_RES_POWER_CTRL, nx() & 16'hfffe, 1'b0);
    rdc("power", IDX_FINE_RES_POWER_CTRL);
    wr(IDX_EDGE_POSITIONER_STEP, nx(), 1'b0);
    rdc("step", IDX_EDGE_POSITIONER_STEP);
    wr(16'h6861, nx(), 1'b1);
    wr(16'h6866, nx(), 1'b1);
    wr(16'h6829, nx(), 1'b1);
    wr(16'h6928, nx(), 1'b1);
    $display("test map done");
    for (int n = 0; n < NM; n++) begin
      o = INSTANCE_STRIDE * n;
      pwe <= 1'b0;
      wr(IDX_FINE_PERIOD_CONTROL + o, nx(), 1'b0);
      rdc("pctl_locked", IDX_FINE_PERIOD_CONTROL + o);
      pwe <= 1'b1;
      wr(IDX_FINE_PERIOD_CONTROL + o, nx() & 16'hfffe, 1'b0);
      rdc("pctl_open", IDX_FINE_PERIOD_CONTROL + o);
    end
    $display("test protect done");
    for (int n = 0; n < NM; n++) begin
      o = INSTANCE_STRIDE * n;
      wr(IDX_PERIOD_EXTENSION_MIRROR + o, nx(), 1'b0);
      wr(IDX_PERIOD_MIRROR + o, nx(), 1'b0);
      wr(IDX_COMPARE_A_EXTENSION_MIRROR + o, nx(), 1'b0);
      wr(IDX_COMPARE_A_MIRROR + o, nx(), 1'b0);
      rdc("act_prd_pre", IDX_ACTIVE_PERIOD + o);
      rdc("act_cmpa_pre", IDX_ACTIVE_COMPARE_A + o);
      load(n);
      rdc("act_prd", IDX_ACTIVE_PERIOD + o);
      rdc("act_cmpa", IDX_ACTIVE_COMPARE_A + o);
    end
    $display("test mirror done");
    cb <= 4'(nx() | 16'h0001);
    ca <= rnd[7:4];
    repeat (4) @(posedge clk_i);
    chk("out_b", {12'h0, cb}, {12'h0, ob});
    chk("out_a", {12'h0, ca}, {12'h0, oa});
    for (int n = 0; n < NM; n++) begin
      o = INSTANCE_STRIDE * n;
      chk("fine_duty", {8'h00, mdl[IDX_COMPARE_A_EXTENSION_MIRROR + o][7:0]},
          {8'h00, micro_edge_positioner[n]});
      wr(IDX_FINE_PERIOD_CONTROL + o, 16'h0001, 1'b0);
    end
    repeat (4) @(posedge clk_i);
    chk("out_b_period", 16'h0000, {12'h0, ob});
    for (int n = 0; n < NM; n++) begin
      o = INSTANCE_STRIDE * n;
      chk("fine_period", {8'h00, 8'(mdl[IDX_PERIOD_EXTENSION_MIRROR + o] +
          mdl[IDX_COMPARE_A_EXTENSION_MIRROR + o])}, {8'h00, micro_edge_positioner[n]});
    end
    $display("test outputs done");
    for (int n = 0; n < NM; n++) begin
      o = INSTANCE_STRIDE * n;
      tbc[n] <= nx();
      mdl[IDX_COMPARE_COUNT_CAPTURE + o] = rnd;
      wr(IDX_COMPARE_TRIP_SELECT + o, 16'h0000, 1'b0);
      wr(IDX_COMPARE_A_CONTROL + o, 16'h0003, 1'b0);
      wr(IDX_COMPARE_B_CONTROL + o, 16'h0003, 1'b0);
      wr(IDX_COMPARE_CAPTURE_CONTROL + o, 16'h0001, 1'b0);
    end
    cmp <= 4'hf;
    repeat (4) @(posedge clk_i);
    chk("dc_a_cmp", 16'h000f, {12'h0, ea});
    for (int n = 0; n < NM; n++) begin
      rdc("capture", IDX_COMPARE_COUNT_CAPTURE + INSTANCE_STRIDE * n);
      wr(IDX_COMPARE_TRIP_SELECT + INSTANCE_STRIDE * n, 16'h0001, 1'b0);
    end
    repeat (4) @(posedge clk_i);
    chk("dc_a_trip", 16'h0000, {12'h0, ea});
    chk("dc_b_cmp", 16'h000f, {12'h0, eb});
    $display("test compare done");
    wr(IDX_FILTER_OFFSET_COUNTER, nx(), 1'b0);
    rdc("offset_cnt", IDX_FILTER_OFFSET_COUNTER);
    wr(IDX_FILTER_WINDOW_COUNTER, nx(), 1'b0);
    rdc("window_cnt", IDX_FILTER_WINDOW_COUNTER);
    wr(IDX_FILTER_WINDOW_VALUE, nx(), 1'b0);
    rdc("window", IDX_FILTER_WINDOW_VALUE);
    $display("test counters done");
    wr(IDX_FINE_RES_POWER_CTRL, 16'h0001, 1'b0);
    busy_seen = 1'b0;
    for (int k = 0; k < 10 && !busy_seen; k++) begin
      @(posedge clk_i);
      busy_seen = (cal_busy_o === 1'b1);
    end
    chk("cal_start", 16'h0001, {15'h0, busy_seen});
    for (int k = 0; k < 300 && cal_busy_o !== 1'b0; k++) begin
      @(posedge clk_i);
    end
    chk("cal_end", 16'h0000, {15'h0, cal_busy_o});
    $display("test calibration done");
    close_out();
  end
endmodule // test_hrx_modulator
